// ===== bench/rxbe_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Readback, nr-only and timer relations
// ****
module rxbe_regs_props (
	input wire clk_sys,
	input wire reset_n,
	input wire [7:0] rd_addr,
	input wire [7:0] rd_data,
	input wire pll_locked,
	input wire strength_detected_flag,
	input wire noise_detected_flag,
	input wire preamble_detected_flag,
	input wire strength_enable,
	input wire noise_enable,
	input wire preamble_enable,
	input wire demod_type_select,
	input wire digital_enable,
	input wire [8:0] comparator_drift_value,
	input wire quick_charge1_active,
	input wire quick_charge2_enable,
	input wire use_nr_only,
	input wire run_mode,
	input wire battery_save_req
);
	wire [2:0] seen;
	assign seen = {strength_detected_flag & strength_enable,
		noise_detected_flag & noise_enable,
		preamble_detected_flag & preamble_enable};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	property p_lock; rd_addr == 8'h1E |=> rd_data[7] == $past(pll_locked); endproperty
	a_lock: assert property (p_lock) else $error("lock bit wrong");
	property p_seen; rd_addr == 8'h1E |=> rd_data[6:4] == $past(seen); endproperty
	a_seen: assert property (p_seen) else $error("detect bits wrong");
	property p_low; rd_addr == 8'h1E |=> rd_data[3:0] == 4'h0; endproperty
	a_low: assert property (p_low) else $error("low bits set");
	property p_fsk; rd_addr == 8'h1F && !demod_type_select |=> rd_data == 8'h00;
	endproperty
	a_fsk: assert property (p_fsk) else $error("peak not zero");
	property p_sat; rd_addr == 8'h20 && digital_enable &&
		comparator_drift_value[8] |=> rd_data == 8'hFF; endproperty
	a_sat: assert property (p_sat) else $error("drift not saturated");
	property p_avg; rd_addr == 8'h21 && !digital_enable |=> rd_data == 8'h00;
	endproperty
	a_avg: assert property (p_avg) else $error("average not zero");
	property p_str; rd_addr == 8'h22 && !strength_enable |=> !rd_data;
	endproperty
	a_str: assert property (p_str) else $error("strength not zero");
	property p_nse; rd_addr == 8'h23 && !noise_enable |=> !rd_data; endproperty
	a_nse: assert property (p_nse) else $error("noise not zero");
	property p_nr; !quick_charge1_active && !quick_charge2_enable |=> use_nr_only;
	endproperty
	a_nr: assert property (p_nr) else $error("nr only missing");
	property p_off; (!run_mode) [*2] |-> !battery_save_req; endproperty
	a_off: assert property (p_off) else $error("save outside run");
endmodule
bind rxbe_regs rxbe_regs_props rxbe_regs_props_inst (.*);
`default_nettype wire

// ===== bench/rxbe_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module rxbe_regs_test;
	logic clk_sys = 1'h0, reset_n = 1'h0, wr_en = 1'h0, eeprom_mode = 1'h0;
	logic run_mode = 1'h0, auto_off_b_enable = 1'h0, quick_charge1_active = 1'h0;
	logic quick_charge1_timeout = 1'h0, quick_charge2_enable = 1'h0;
	logic ref_above_threshold = 1'h0, demod_type_select = 1'h0;
	logic digital_enable = 1'h0, pll_locked = 1'h0, strength_enable = 1'h0;
	logic strength_detected_flag = 1'h0, noise_detected_flag = 1'h0;
	logic preamble_detected_flag = 1'h0, noise_enable = 1'h0;
	logic preamble_enable = 1'h0, use_nr_only, peak_coeffs_valid;
	logic battery_save_req;
	logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, rd_addr = 8'h00, rd_data;
	logic [7:0] peak_raw_value = 8'h00, comparator_average_value = 8'h77;
	logic [7:0] strength_level_value = 8'h33, noise_level_value = 8'h4C;
	logic [8:0] comparator_drift_value = 9'h100;
	logic [10:0] comparator_tracking_divider;
	logic [9:0] peak_discharge_coeff;
	logic [6:0] peak_charge_coeff;
	logic [1:0] notch_centre_select;
	logic [10:0] nr_t [8] = '{11'h080, 11'h0AA, 11'h100, 11'h155,
		11'h200, 11'h2AA, 11'h400, 11'h555};
	int n_fail = 0, samples_checked = 0, c;
	rxbe_regs #(.UNIT_CYCLES(32'd4)) rxbe_regs_inst (.*);
	always #2 clk_sys = ~clk_sys;
	task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr_en <= 1'h1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk_sys);
		wr_en <= 1'h0;
		@(posedge clk_sys);
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		rd_addr <= a;
		@(posedge clk_sys);
		#1 chk("rd_data", {3'h0, e}, {3'h0, rd_data});
	endtask
	task results;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task wait_req;
		c = 0;
		while (battery_save_req !== 1'h1) begin
			@(posedge clk_sys);
			#1 c++;
			if (c > 60) begin
				chk("timer", 11'h001, 11'h000);
				results;
			end
		end
	endtask
	task t_codes;
		logic [3:0] i;
		quick_charge2_enable <= 1'h1;
		demod_type_select <= 1'h1;
		for (i = 0; i < 8; i++) begin
			wr(8'h1B, {2'h1, i[2:0], i[1:0], 1'h1});
			chk("nr", nr_t[i], comparator_tracking_divider);
			chk("notch", {9'h000, i[1:0]}, {9'h000, notch_centre_select});
			wr(8'h1C, {i[2:0], i[1:0], 3'h2});
			chk("tr", nr_t[i] >> 1, {1'h0, peak_discharge_coeff});
			chk("tp", 11'h008 << i[1:0], {4'h0, peak_charge_coeff});
			chk("valid", 11'h001, {10'h000, peak_coeffs_valid});
		end
		rd(8'h1C, 8'hFA);
		quick_charge2_enable <= 1'h0;
		rd(8'h30, 8'h00);
		chk("valid", 11'h000, {10'h000, peak_coeffs_valid});
		chk("nr_only", 11'h001, {10'h000, use_nr_only});
		quick_charge2_enable <= 1'h1;
		ref_above_threshold <= 1'h1;
		rd(8'h30, 8'h00);
		chk("nr_qc2", 11'h000, {10'h000, use_nr_only});
		quick_charge1_timeout <= 1'h1;
		rd(8'h30, 8'h00);
		chk("nr_qc1t", 11'h001, {10'h000, use_nr_only});
		quick_charge1_timeout <= 1'h0;
		ref_above_threshold <= 1'h0;
		rd(8'h30, 8'h00);
		chk("nr_below", 11'h001, {10'h000, use_nr_only});
		quick_charge2_enable <= 1'h0;
		$display("coefficient codes done");
	endtask
	task t_mon;
		pll_locked <= 1'h1;
		strength_detected_flag <= 1'h1;
		noise_detected_flag <= 1'h1;
		preamble_detected_flag <= 1'h1;
		strength_enable <= 1'h1;
		noise_enable <= 1'h1;
		rd(8'h1E, 8'hE0);
		pll_locked <= 1'h0;
		preamble_enable <= 1'h1;
		peak_raw_value <= 8'h5A;
		digital_enable <= 1'h1;
		rd(8'h1E, 8'h70);
		rd(8'h1F, 8'h5A);
		rd(8'h20, 8'hFF);
		comparator_drift_value <= 9'h05A;
		rd(8'h20, 8'h5A);
		rd(8'h21, 8'h77);
		rd(8'h22, 8'h33);
		rd(8'h23, 8'h4C);
		demod_type_select <= 1'h0;
		digital_enable <= 1'h0;
		strength_enable <= 1'h0;
		noise_enable <= 1'h0;
		rd(8'h1F, 8'h00);
		rd(8'h20, 8'h00);
		rd(8'h21, 8'h00);
		rd(8'h22, 8'h00);
		rd(8'h23, 8'h00);
		strength_detected_flag <= 1'h0;
		noise_detected_flag <= 1'h0;
		preamble_detected_flag <= 1'h0;
		$display("monitors done");
	endtask
	task t_timer;
		auto_off_b_enable <= 1'h1;
		wr(8'h1D, 8'h03);
		run_mode <= 1'h1;
		// Write in run must not shorten the running period
		wr(8'h1D, 8'h01);
		wait_req;
		// Two units of four cycles, counted from two edges after run
		chk("period", 11'h001, {10'h000, c > 5 && c < 11});
		run_mode <= 1'h0;
		repeat (3) @(posedge clk_sys);
		run_mode <= 1'h1;
		wait_req;
		chk("short", 11'h001, {10'h000, c < 4});
		run_mode <= 1'h0;
		strength_detected_flag <= 1'h1;
		repeat (2) @(posedge clk_sys);
		run_mode <= 1'h1;
		repeat (20) @(posedge clk_sys);
		#1 chk("detect_stop", 11'h000, {10'h000, battery_save_req});
		strength_detected_flag <= 1'h0;
		eeprom_mode <= 1'h1;
		wr(8'h1D, 8'h09);
		rd(8'h1D, 8'h01);
		$display("timer done");
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'h1;
		rd(8'h1B, 8'h60);
		rd(8'h1C, 8'h88);
		rd(8'h1D, 8'h00);
		t_codes;
		t_mon;
		t_timer;
		results;
	end
endmodule
`default_nettype wire

// ===== rtl/rxbe_consts.vh
`ifndef RXBE_CONSTS_VH
`define RXBE_CONSTS_VH
// ****************************************
// Register offsets
// ****************************************
`define RXBE_ADDR_COMPARATOR 8'h1B
`define RXBE_ADDR_PEAK_HOLD 8'h1C
`define RXBE_ADDR_AUTO_OFF 8'h1D
`define RXBE_ADDR_DETECT 8'h1E
`define RXBE_ADDR_PEAK_LEVEL 8'h1F
`define RXBE_ADDR_DRIFT 8'h20
`define RXBE_ADDR_AVERAGE 8'h21
`define RXBE_ADDR_STRENGTH 8'h22
`define RXBE_ADDR_NOISE 8'h23
// ****************************************
// Reset values
// ****************************************
`define RXBE_RST_COMPARATOR 8'h60
`define RXBE_RST_PEAK_HOLD 8'h88
`define RXBE_RST_AUTO_OFF 8'h00
// ****************************************
// Field positions
// ****************************************
`define RXBE_CMP_DIV_HI 5
`define RXBE_CMP_DIV_LO 3
`define RXBE_NOTCH_HI 2
`define RXBE_NOTCH_LO 1
`define RXBE_PK_DIS_HI 7
`define RXBE_PK_DIS_LO 5
`define RXBE_PK_CHG_HI 4
`define RXBE_PK_CHG_LO 3
`define RXBE_DET_LOCK 7
`define RXBE_DET_STRENGTH 6
`define RXBE_DET_NOISE 5
`define RXBE_DET_PREAMBLE 4
// ****************************************
// Timing: ref clock 30.32 MHz, unit 2^15 ref periods
// ****************************************
`define RXBE_REF_CLK_HZ 30320000
`define RXBE_SYS_CLK_HZ 250000000
`define RXBE_REF_UNIT 32768
`define RXBE_ZERO_SETTING_UNITS 9'h0FF
// 2^15 reference periods counted in 4 ns system cycles
`define RXBE_UNIT_CYCLES 32'h0004_1F69
`endif

// ===== rtl/rxbe_regs.v
// Contract
// [R1] Comparator divider code selects tracking nr
// [R2] Nr-only tracking outside quick charge cases
// [R3] Notch code selects centre frequency
// [R4] Host sets notch trim bits for filter
// [R5] Host sets trims per detection type
// [R6] Discharge code selects tr, ASK+QC2
// [R7] Charge code selects tp, ASK+QC2
// [R8] AutoOff B timeout enters battery saving
// [R9] Period 2^15 ref times n-1, zero 255
// [R10] Delay count latched on entering run
// [R11] EEPROM mode holds delay count
// [R12] Bit 7 shows PLL lock
// [R13] Bits 6..4 show detector outputs
// [R14] Low four detect bits read zero
// [R15] Peak level reads zero in FSK
// [R16] ASK peak level without quick charge
// [R17] Drift saturates, zero when disabled
// [R18] Average reads zero when disabled
// [R19] Strength reads zero when disabled
// [R20] Noise level reads zero when disabled
`timescale 1ns/10ps
`default_nettype none
`include "rxbe_consts.vh"
module rxbe_regs #(
	parameter [31:0] UNIT_CYCLES = `RXBE_UNIT_CYCLES
) (
	input wire clk_sys,
	input wire reset_n,
	input wire wr_en,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	input wire [7:0] rd_addr,
	output reg [7:0] rd_data,
	input wire eeprom_mode,
	input wire run_mode,
	input wire auto_off_b_enable,
	input wire quick_charge1_active,
	input wire quick_charge1_timeout,
	input wire quick_charge2_enable,
	input wire ref_above_threshold,
	input wire demod_type_select,
	input wire digital_enable,
	input wire pll_locked,
	input wire strength_detected_flag,
	input wire noise_detected_flag,
	input wire preamble_detected_flag,
	input wire strength_enable,
	input wire noise_enable,
	input wire preamble_enable,
	input wire [7:0] peak_raw_value,
	input wire [8:0] comparator_drift_value,
	input wire [7:0] comparator_average_value,
	input wire [7:0] strength_level_value,
	input wire [7:0] noise_level_value,
	output reg [10:0] comparator_tracking_divider,
	output reg [1:0] notch_centre_select,
	output reg use_nr_only,
	output reg [9:0] peak_discharge_coeff,
	output reg [6:0] peak_charge_coeff,
	output reg peak_coeffs_valid,
	output reg battery_save_req
);
	// ****************************************
	// Decoding helpers
	// ****************************************
	// Divider in units of 1/3 to keep x.3 and x.7 exact
	function [12:0] thirds_div;
		input [2:0] code;
		input [9:0] base;
		begin
			if (code[0])
				thirds_div = {3'b000, base} * 13'd4 << (code[2:1]);
			else
				thirds_div = {3'b000, base} * 13'd3 << (code[2:1]);
		end
	endfunction

	function write_hit;
		input en;
		input [7:0] a;
		input [7:0] target;
		begin
			write_hit = en && (a == target);
		end
	endfunction

	// ****************************************
	// Writable registers
	// ****************************************
	reg [7:0] comparator_settings;
	reg [7:0] peak_hold_settings;
	reg [7:0] auto_off_b_duration;
	reg run_q;
	wire enter_run = run_mode && !run_q;

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			comparator_settings <= `RXBE_RST_COMPARATOR;
			peak_hold_settings <= `RXBE_RST_PEAK_HOLD;
			auto_off_b_duration <= `RXBE_RST_AUTO_OFF;
			run_q <= 1'b0;
		end else begin
			run_q <= run_mode;
			if (write_hit(wr_en, wr_addr, `RXBE_ADDR_COMPARATOR))
				comparator_settings <= wr_data;
			if (write_hit(wr_en, wr_addr, `RXBE_ADDR_PEAK_HOLD))
				peak_hold_settings <= wr_data;
			if (write_hit(wr_en, wr_addr, `RXBE_ADDR_AUTO_OFF) &&
					!eeprom_mode)
				auto_off_b_duration <= wr_data; // [R11]
		end
	end

	// ****************************************
	// Coefficient outputs
	// ****************************************
	wire [2:0] cmp_code = comparator_settings[`RXBE_CMP_DIV_HI:
		`RXBE_CMP_DIV_LO];
	wire [2:0] dis_code = peak_hold_settings[`RXBE_PK_DIS_HI:
		`RXBE_PK_DIS_LO];
	wire [1:0] chg_code = peak_hold_settings[`RXBE_PK_CHG_HI:
		`RXBE_PK_CHG_LO];
	wire [12:0] cmp_thirds = thirds_div(cmp_code, 10'd128);
	wire [12:0] dis_thirds = thirds_div(dis_code, 10'd64);
	// Largest code gives 1365, so eleven bits always suffice
	wire [12:0] cmp_whole = cmp_thirds / 13'd3;
	wire [12:0] dis_whole = dis_thirds / 13'd3;

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			comparator_tracking_divider <= 11'h000;
			notch_centre_select <= 2'b00;
			use_nr_only <= 1'b1;
			peak_discharge_coeff <= 10'h000;
			peak_charge_coeff <= 7'h00;
			peak_coeffs_valid <= 1'b0;
		end else begin
			// Whole part of nr, thirds truncated
			comparator_tracking_divider <= cmp_whole[10:0]; // [R1]
			notch_centre_select <= comparator_settings[`RXBE_NOTCH_HI:
				`RXBE_NOTCH_LO]; // [R3]
			use_nr_only <= (!quick_charge1_active &&
				!quick_charge2_enable) || quick_charge1_timeout ||
				!ref_above_threshold; // [R2]
			peak_discharge_coeff <= dis_whole[9:0]; // [R6]
			peak_charge_coeff <= 7'd8 << chg_code; // [R7]
			peak_coeffs_valid <= demod_type_select &&
				quick_charge2_enable; // [R6] [R7]
		end
	end

	// ****************************************
	// AutoOff Type B timer
	// ****************************************
	wire unit_tick;
	reg [8:0] units_left;
	reg timer_armed;
	wire any_detect = strength_detected_flag || noise_detected_flag ||
		preamble_detected_flag;

	rxbe_tick_gen #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) rxbe_tick_gen_inst (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.run(timer_armed),
		.tick(unit_tick)
	);

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			units_left <= 9'h000;
			timer_armed <= 1'b0;
			battery_save_req <= 1'b0;
		end else if (!run_mode) begin
			timer_armed <= 1'b0;
			battery_save_req <= 1'b0;
		end else if (enter_run) begin
			// Latch happens this edge, so load from the source
			units_left <= (auto_off_b_duration == 8'h00) ?
				`RXBE_ZERO_SETTING_UNITS :
				{1'b0, auto_off_b_duration} - 9'd1; // [R9] [R10]
			timer_armed <= auto_off_b_enable;
		end else if (timer_armed) begin
			if (any_detect || !auto_off_b_enable) begin
				timer_armed <= 1'b0;
			end else if (units_left == 9'h000) begin
				battery_save_req <= 1'b1; // [R8]
				timer_armed <= 1'b0;
			end else if (unit_tick) begin
				units_left <= units_left - 9'd1; // [R9]
			end
		end
	end

	// ****************************************
	// Read mux, registered
	// ****************************************
	reg [7:0] next_rd_data;
	always @* begin
		next_rd_data = 8'h00;
		case (rd_addr)
		`RXBE_ADDR_COMPARATOR: next_rd_data = comparator_settings;
		`RXBE_ADDR_PEAK_HOLD: next_rd_data = peak_hold_settings;
		`RXBE_ADDR_AUTO_OFF: next_rd_data = auto_off_b_duration;
		`RXBE_ADDR_DETECT: begin
			next_rd_data[`RXBE_DET_LOCK] = pll_locked; // [R12]
			next_rd_data[`RXBE_DET_STRENGTH] = strength_enable &&
				strength_detected_flag; // [R13]
			next_rd_data[`RXBE_DET_NOISE] = noise_enable &&
				noise_detected_flag; // [R13]
			next_rd_data[`RXBE_DET_PREAMBLE] = preamble_enable &&
				preamble_detected_flag; // [R13]
			next_rd_data[3:0] = 4'h0; // [R14]
		end
		`RXBE_ADDR_PEAK_LEVEL:
			next_rd_data = demod_type_select ? peak_raw_value :
				8'h00; // [R15] [R16]
		`RXBE_ADDR_DRIFT:
			next_rd_data = !digital_enable ? 8'h00 :
				(comparator_drift_value[8] ? 8'hFF :
				comparator_drift_value[7:0]); // [R17]
		`RXBE_ADDR_AVERAGE:
			next_rd_data = digital_enable ?
				comparator_average_value : 8'h00; // [R18]
		`RXBE_ADDR_STRENGTH:
			next_rd_data = strength_enable ?
				strength_level_value : 8'h00; // [R19]
		`RXBE_ADDR_NOISE:
			next_rd_data = noise_enable ? noise_level_value :
				8'h00; // [R20]
		default: next_rd_data = 8'h00;
		endcase
	end

	always @(posedge clk_sys) begin
		if (!reset_n)
			rd_data <= 8'h00;
		else
			rd_data <= next_rd_data;
	end
endmodule
`default_nettype wire

// ===== rtl/rxbe_tick_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "rxbe_consts.vh"
// ****************************************
// Timer unit tick: one pulse per 2^15 reference periods
// ****************************************
module rxbe_tick_gen #(
	parameter [31:0] UNIT_CYCLES = `RXBE_UNIT_CYCLES
) (
	input wire clk_sys,
	input wire reset_n,
	input wire run,
	output reg tick
);
	reg [31:0] count;
	always @(posedge clk_sys) begin
		if (!reset_n || !run) begin
			count <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (count >= UNIT_CYCLES - 32'd1) begin
			count <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			count <= count + 32'd1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire
